// >>> shared/torque_cond_pkg.sv
// Constants, register map and types shared by the torque command conditioning block
package torque_cond_pkg;

   // Data widths
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CMD_W    = 16;
   localparam int unsigned PCT_W    = 11;
   localparam int unsigned BIAS_W   = 14;
   localparam int unsigned TC_W     = 13;
   localparam int unsigned LIM_W    = 7;
   localparam int unsigned SCALED_W = 29;
   localparam int unsigned NUM_W    = 36;
   localparam int unsigned DEN_W    = 23;
   localparam int unsigned CNT_W    = 6;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MAX_PCT  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BIAS     = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FILT_TC  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_LIM_PRI  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_LIM_SEC  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_DEMAND   = 8'h1C;

   // Field positions
   localparam int unsigned CTRL_TORQUE_MODE_BIT = 0;
   localparam int unsigned CTRL_LSEL_ASSIGN_BIT = 1;
   localparam int unsigned STAT_LSEL_BIT        = 0;
   localparam int unsigned STAT_CLAMP_BIT       = 1;
   localparam int unsigned STAT_BUSY_BIT        = 2;

   // Reset values
   localparam logic [1:0]        CTRL_RST    = 2'h1;
   localparam logic [PCT_W-1:0]  MAX_PCT_RST = 11'h064;
   localparam logic [BIAS_W-1:0] BIAS_RST    = 14'h0000;
   localparam logic [TC_W-1:0]   FILT_TC_RST = 13'h0000;
   localparam logic [LIM_W-1:0]  LIM_RST     = 7'h64;

   // Setting ranges, as 32-bit words for write saturation
   localparam logic [31:0] MAX_PCT_HI = 32'h0000_07D0;
   localparam logic [31:0] BIAS_HI    = 32'h0000_1F40;
   localparam logic [31:0] BIAS_LO    = 32'hFFFF_E0C0;
   localparam logic [31:0] FILT_TC_HI = 32'h0000_1388;
   localparam logic [31:0] LIM_HI     = 32'h0000_0064;

   // Scaling and timing: demand unit is 1e-4 percent of rated torque
   localparam logic [SCALED_W-1:0] UNITS_PER_PCT    = 29'h0000_2710;
   localparam logic [DEN_W-1:0]    US_PER_MS        = 23'h00_03E8;
   localparam logic [DEN_W-1:0]    SAMPLE_PERIOD_US = 23'h00_0064;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Datapath sequence, Gray coded
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_FILTER = 2'b01,
      ST_DIVIDE = 2'b11,
      ST_OUTPUT = 2'b10
   } path_state_t;

endpackage

// >>> src/serial_divider.sv
// Iterative restoring divider for the smoothing filter step
module serial_divider
   import torque_cond_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          srst,
   // Request
   input  wire logic                          start,
   input  wire logic [torque_cond_pkg::NUM_W-1:0] num,
   input  wire logic [torque_cond_pkg::DEN_W-1:0] den,
   // Result
   output logic                               busy,
   output logic                               done,
   output logic [torque_cond_pkg::NUM_W-1:0]  quo
);
   import torque_cond_pkg::*;

   logic             busy_reg, busy_next;
   logic             done_reg, done_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [DEN_W:0]   rem_reg, rem_next;
   logic [NUM_W-1:0] quo_reg, quo_next;
   logic [DEN_W:0]   shifted;

   always_comb begin
      busy_next = busy_reg;
      cnt_next  = cnt_reg;
      rem_next  = rem_reg;
      quo_next  = quo_reg;
      done_next = 1'b0;
      shifted   = {rem_reg[DEN_W-1:0], quo_reg[NUM_W-1]};
      if (start && !busy_reg) begin
         busy_next = 1'b1;
         cnt_next  = CNT_W'(NUM_W);
         rem_next  = '0;
         quo_next  = num;
      end else if (busy_reg) begin
         // Denominator never zero: sample period is always added
         if (shifted >= {1'b0, den}) begin
            rem_next = shifted - {1'b0, den};
            quo_next = {quo_reg[NUM_W-2:0], 1'b1};
         end else begin
            rem_next = shifted;
            quo_next = {quo_reg[NUM_W-2:0], 1'b0};
         end
         cnt_next = cnt_reg - 1'b1;
         if (cnt_reg == 1) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         cnt_reg  <= '0;
         rem_reg  <= '0;
         quo_reg  <= '0;
      end else begin
         busy_reg <= busy_next;
         done_reg <= done_next;
         cnt_reg  <= cnt_next;
         rem_reg  <= rem_next;
         quo_reg  <= quo_next;
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;
   assign quo  = quo_reg;
endmodule

// >>> src/torque_command_conditioning.sv
// Torque command scaling, offset, smoothing and limiting with an AXI4-Lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module torque_command_conditioning
   import torque_cond_pkg::*;
(
   // Clock and reset
   input  wire logic                                 REF_CLK,
   input  wire logic                                 SRST,
   // AXI4-Lite write address
   input  wire logic [torque_cond_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
   input  wire logic                                 S_AXI_AWVALID,
   output logic                                      S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [torque_cond_pkg::DATA_W-1:0]   S_AXI_WDATA,
   input  wire logic [3:0]                           S_AXI_WSTRB,
   input  wire logic                                 S_AXI_WVALID,
   output logic                                      S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]                                S_AXI_BRESP,
   output logic                                      S_AXI_BVALID,
   input  wire logic                                 S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire logic [torque_cond_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
   input  wire logic                                 S_AXI_ARVALID,
   output logic                                      S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [torque_cond_pkg::DATA_W-1:0]        S_AXI_RDATA,
   output logic [1:0]                                S_AXI_RRESP,
   output logic                                      S_AXI_RVALID,
   input  wire logic                                 S_AXI_RREADY,
   // Digitised torque command in millivolts
   input  wire logic signed [torque_cond_pkg::CMD_W-1:0] CMD_MV,
   input  wire logic                                 CMD_VALID,
   output logic                                      CMD_READY,
   // Limit select contact, low when shorted to signal ground
   input  wire logic                                 LIMIT_SELECT_CONTACT_N,
   // Conditioned torque demand to the torque loop
   output logic signed [torque_cond_pkg::SCALED_W-1:0] TORQUE_DEMAND,
   output logic                                      TORQUE_VALID
);
   import torque_cond_pkg::*;

   function automatic logic [31:0] merge_strb(logic [31:0] old, logic [31:0] data, logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] clamp_u(logic [31:0] v, logic [31:0] hi);
      return (v > hi) ? hi : v;
   endfunction

   function automatic logic [31:0] clamp_s(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
      logic [31:0] res;
      res = v;
      if ($signed(v) > $signed(hi)) begin
         res = hi;
      end else if ($signed(v) < $signed(lo)) begin
         res = lo;
      end
      return res;
   endfunction

   // Pin synchroniser
   logic sync1_reg, sync2_reg;
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= LIMIT_SELECT_CONTACT_N;
         sync2_reg <= sync1_reg;
      end
   end

   // Bus and settings state
   logic                    aw_held_reg, aw_held_next;
   logic [ADDR_W-1:0]       awaddr_reg, awaddr_next;
   logic                    w_held_reg, w_held_next;
   logic [DATA_W-1:0]       wdata_reg, wdata_next;
   logic [3:0]              wstrb_reg, wstrb_next;
   logic                    bvalid_reg, bvalid_next;
   logic [1:0]              bresp_reg, bresp_next;
   logic                    rvalid_reg, rvalid_next;
   logic [DATA_W-1:0]       rdata_reg, rdata_next;
   logic [1:0]              rresp_reg, rresp_next;
   logic [1:0]              ctrl_reg, ctrl_next;
   logic [PCT_W-1:0]        max_command_torque_pct_reg, max_command_torque_pct_next;
   logic signed [BIAS_W-1:0] torque_cmd_bias_mv_reg, torque_cmd_bias_mv_next;
   logic [TC_W-1:0]         torque_cmd_filter_tc_reg, torque_cmd_filter_tc_next;
   logic [LIM_W-1:0]        torque_limit_primary_reg, torque_limit_primary_next;
   logic [LIM_W-1:0]        torque_limit_secondary_reg, torque_limit_secondary_next;

   // Datapath state
   path_state_t               state_reg, state_next;
   logic signed [SCALED_W-1:0] scaled_reg, scaled_next;
   logic signed [SCALED_W-1:0] filt_reg, filt_next;
   logic signed [SCALED_W-1:0] demand_reg, demand_next;
   logic                       tvalid_reg, tvalid_next;
   logic                       clamp_reg, clamp_next;

   logic                 limit_select_input;
   logic                 aw_hs, w_hs, ar_hs;
   logic [31:0]          merged;
   logic [DATA_W-1:0]    status_word;
   logic                 bypass;
   logic                 div_start, div_busy, div_done;
   logic [NUM_W-1:0]     div_quo;
   logic signed [SCALED_W:0] err;
   logic [SCALED_W:0]    err_mag;
   logic [NUM_W-1:0]     div_num;
   logic [DEN_W-1:0]     div_den;

   // Unassigned input keeps the primary limit
   assign limit_select_input = ctrl_reg[CTRL_LSEL_ASSIGN_BIT] && !sync2_reg;

   assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_hs  = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
   assign S_AXI_ARREADY = !rvalid_reg;

   always_comb begin
      status_word = '0;
      status_word[STAT_LSEL_BIT]  = limit_select_input;
      status_word[STAT_CLAMP_BIT] = clamp_reg;
      status_word[STAT_BUSY_BIT]  = (state_reg != ST_IDLE) || div_busy;
   end

   always_comb begin
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      ctrl_next                   = ctrl_reg;
      max_command_torque_pct_next = max_command_torque_pct_reg;
      torque_cmd_bias_mv_next     = torque_cmd_bias_mv_reg;
      torque_cmd_filter_tc_next   = torque_cmd_filter_tc_reg;
      torque_limit_primary_next   = torque_limit_primary_reg;
      torque_limit_secondary_next = torque_limit_secondary_reg;
      merged = '0;
      if (aw_hs) begin
         aw_held_next = 1'b1;
         awaddr_next  = S_AXI_AWADDR;
      end
      if (w_hs) begin
         w_held_next = 1'b1;
         wdata_next  = S_AXI_WDATA;
         wstrb_next  = S_AXI_WSTRB;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (aw_held_reg && w_held_reg) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         // Out-of-range settings saturate rather than wrap
         if (awaddr_reg == OFF_CTRL) begin
            merged    = merge_strb(32'(ctrl_reg), wdata_reg, wstrb_reg);
            ctrl_next = merged[1:0];
         end else if (awaddr_reg == OFF_MAX_PCT) begin
            merged = merge_strb(32'(max_command_torque_pct_reg), wdata_reg, wstrb_reg);
            max_command_torque_pct_next = PCT_W'(clamp_u(merged, MAX_PCT_HI));
         end else if (awaddr_reg == OFF_BIAS) begin
            merged = merge_strb(32'(torque_cmd_bias_mv_reg), wdata_reg, wstrb_reg);
            torque_cmd_bias_mv_next = BIAS_W'(clamp_s(merged, BIAS_LO, BIAS_HI));
         end else if (awaddr_reg == OFF_FILT_TC) begin
            merged = merge_strb(32'(torque_cmd_filter_tc_reg), wdata_reg, wstrb_reg);
            torque_cmd_filter_tc_next = TC_W'(clamp_u(merged, FILT_TC_HI));
         end else if (awaddr_reg == OFF_LIM_PRI) begin
            merged = merge_strb(32'(torque_limit_primary_reg), wdata_reg, wstrb_reg);
            torque_limit_primary_next = LIM_W'(clamp_u(merged, LIM_HI));
         end else if (awaddr_reg == OFF_LIM_SEC) begin
            merged = merge_strb(32'(torque_limit_secondary_reg), wdata_reg, wstrb_reg);
            torque_limit_secondary_next = LIM_W'(clamp_u(merged, LIM_HI));
         end else if (awaddr_reg == OFF_STATUS || awaddr_reg == OFF_DEMAND) begin
            bresp_next = RESP_OKAY;
         end else begin
            bresp_next = RESP_SLVERR;
         end
      end
      if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      if (ar_hs) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         rdata_next  = '0;
         if (S_AXI_ARADDR == OFF_CTRL) begin
            rdata_next = 32'(ctrl_reg);
         end else if (S_AXI_ARADDR == OFF_MAX_PCT) begin
            rdata_next = 32'(max_command_torque_pct_reg);
         end else if (S_AXI_ARADDR == OFF_BIAS) begin
            rdata_next = 32'(torque_cmd_bias_mv_reg);
         end else if (S_AXI_ARADDR == OFF_FILT_TC) begin
            rdata_next = 32'(torque_cmd_filter_tc_reg);
         end else if (S_AXI_ARADDR == OFF_LIM_PRI) begin
            rdata_next = 32'(torque_limit_primary_reg);
         end else if (S_AXI_ARADDR == OFF_LIM_SEC) begin
            rdata_next = 32'(torque_limit_secondary_reg);
         end else if (S_AXI_ARADDR == OFF_STATUS) begin
            rdata_next = status_word;
         end else if (S_AXI_ARADDR == OFF_DEMAND) begin
            rdata_next = 32'(demand_reg);
         end else begin
            rresp_next = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
         ctrl_reg                   <= CTRL_RST;
         max_command_torque_pct_reg <= MAX_PCT_RST;
         torque_cmd_bias_mv_reg     <= BIAS_RST;
         torque_cmd_filter_tc_reg   <= FILT_TC_RST;
         torque_limit_primary_reg   <= LIM_RST;
         torque_limit_secondary_reg <= LIM_RST;
      end else begin
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         ctrl_reg                   <= ctrl_next;
         max_command_torque_pct_reg <= max_command_torque_pct_next;
         torque_cmd_bias_mv_reg     <= torque_cmd_bias_mv_next;
         torque_cmd_filter_tc_reg   <= torque_cmd_filter_tc_next;
         torque_limit_primary_reg   <= torque_limit_primary_next;
         torque_limit_secondary_reg <= torque_limit_secondary_next;
      end
   end

   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP  = bresp_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA  = rdata_reg;
   assign S_AXI_RRESP  = rresp_reg;

   // Smoothing step: y += (x - y) * Ts / (tau + Ts)
   assign bypass  = (torque_cmd_filter_tc_reg == '0) || !ctrl_reg[CTRL_TORQUE_MODE_BIT];
   assign err     = (SCALED_W+1)'(scaled_reg) - (SCALED_W+1)'(filt_reg);
   assign err_mag = err[SCALED_W] ? (SCALED_W+1)'(-err) : (SCALED_W+1)'(err);
   assign div_num = NUM_W'(err_mag) * NUM_W'(SAMPLE_PERIOD_US);
   assign div_den = DEN_W'(torque_cmd_filter_tc_reg) * US_PER_MS + SAMPLE_PERIOD_US;
   assign div_start = (state_reg == ST_FILTER) && !bypass;

   serial_divider u_div (
      .clk   (REF_CLK),
      .srst  (SRST),
      .start (div_start),
      .num   (div_num),
      .den   (div_den),
      .busy  (div_busy),
      .done  (div_done),
      .quo   (div_quo)
   );

   logic signed [CMD_W:0]      diff;
   logic signed [SCALED_W:0]   step;
   logic [LIM_W-1:0]           lim_pct;
   logic signed [SCALED_W-1:0] lim_units;

   // Samples offered while busy wait on CMD_READY
   assign CMD_READY = (state_reg == ST_IDLE);

   always_comb begin
      state_next  = state_reg;
      scaled_next = scaled_reg;
      filt_next   = filt_reg;
      demand_next = demand_reg;
      clamp_next  = clamp_reg;
      tvalid_next = 1'b0;
      diff = (CMD_W+1)'(CMD_MV) - (CMD_W+1)'(torque_cmd_bias_mv_reg);
      step = err[SCALED_W] ? -(SCALED_W+1)'(div_quo) : (SCALED_W+1)'(div_quo);
      if (limit_select_input && (torque_limit_secondary_reg < torque_limit_primary_reg)) begin
         lim_pct = torque_limit_secondary_reg;
      end else begin
         lim_pct = torque_limit_primary_reg;
      end
      lim_units = $signed(SCALED_W'(lim_pct) * UNITS_PER_PCT);
      case (state_reg)
         ST_IDLE: begin
            if (CMD_VALID) begin
               // Millivolts times percent gives 1e-4 percent units, so 10 V maps to the setting
               scaled_next = SCALED_W'(diff) * $signed({1'b0, max_command_torque_pct_reg});
               state_next  = ST_FILTER;
            end
         end
         ST_FILTER: begin
            if (bypass) begin
               filt_next  = scaled_reg;
               state_next = ST_OUTPUT;
            end else begin
               state_next = ST_DIVIDE;
            end
         end
         ST_DIVIDE: begin
            if (div_done) begin
               filt_next  = SCALED_W'((SCALED_W+1)'(filt_reg) + step);
               state_next = ST_OUTPUT;
            end
         end
         ST_OUTPUT: begin
            clamp_next = 1'b1;
            if (filt_reg > lim_units) begin
               demand_next = lim_units;
            end else if (filt_reg < -lim_units) begin
               demand_next = -lim_units;
            end else begin
               demand_next = filt_reg;
               clamp_next  = 1'b0;
            end
            tvalid_next = 1'b1;
            state_next  = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_reg  <= ST_IDLE;
         scaled_reg <= '0;
         filt_reg   <= '0;
         demand_reg <= '0;
         tvalid_reg <= 1'b0;
         clamp_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         scaled_reg <= scaled_next;
         filt_reg   <= filt_next;
         demand_reg <= demand_next;
         tvalid_reg <= tvalid_next;
         clamp_reg  <= clamp_next;
      end
   end

   assign TORQUE_DEMAND = demand_reg;
   assign TORQUE_VALID  = tvalid_reg;
endmodule

// >>> sim/torque_cond_sva.sv
// Port assertions for the torque command conditioning block
module torque_cond_sva (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // Register bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   // Command path
   input wire logic CMD_VALID,
   input wire logic CMD_READY,
   input wire logic TORQUE_VALID
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   sequence s_take;
      CMD_VALID && CMD_READY;
   endsequence
   sequence s_write;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   // Filtered path is the slow one, so the window covers both
   a_out_latency: assert property (s_take |-> ##[3:45] TORQUE_VALID)
      else $error("no output after command");
   a_no_early_out: assert property (s_take |=> !TORQUE_VALID [*2])
      else $error("output too early");
   a_ready_held: assert property (s_take |=> !CMD_READY [*2])
      else $error("command accepted while busy");
   a_ready_on_out: assert property (TORQUE_VALID |-> CMD_READY)
      else $error("not idle at output");
   a_valid_single: assert property (TORQUE_VALID |=> !TORQUE_VALID)
      else $error("output pulse too long");
   a_write_resp: assert property (s_write |-> ##[1:2] S_AXI_BVALID)
      else $error("write not answered");
   a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken during response");
   a_read_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered");
endmodule
bind torque_command_conditioning torque_cond_sva chk_i (.*);

// >>> sim/cmd_source_model.sv
// Torque command source and limit select contact
module cmd_source_model
   import torque_cond_pkg::*;
(
   // Clock
   input  wire logic                                clk,
   // Command handshake
   output logic signed [torque_cond_pkg::CMD_W-1:0] cmd_mv,
   output logic                                     cmd_valid,
   input  wire logic                                cmd_ready,
   // Contact, low when shorted to signal ground
   output logic                                     contact_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_mv = '0;
      cmd_valid = 1'b0;
      contact_n = 1'b1;
   end
   // Sample held until taken, then the line no longer shows it
   task automatic send(input logic signed [CMD_W-1:0] mv);
      int n = 0;
      cmd_mv <= mv;
      cmd_valid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      cmd_valid <= 1'b0;
      cmd_mv <= ~mv;
   endtask
   task automatic set_contact(input logic open_n);
      contact_n <= open_n;
   endtask
endmodule

// >>> sim/torque_command_conditioning_tb_top.sv
// Self-checking bench for the torque command conditioning block
module torque_command_conditioning_tb_top
   import torque_cond_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] aw_a = '0, ar_a = '0;
   logic [31:0] w_d = '0, r_d;
   logic [3:0] w_s = 4'hF;
   logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, c_v, c_rdy, c_n, t_v;
   logic [1:0] b_rs, r_rs;
   logic signed [CMD_W-1:0] c_mv;
   logic signed [SCALED_W-1:0] t_d;
   int n_fail = 0, compares = 0, cyc = 0;
   torque_command_conditioning DUT (.REF_CLK(clk), .SRST(srst),
      .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
      .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
      .S_AXI_BRESP(b_rs), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
      .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rs), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
      .CMD_MV(c_mv), .CMD_VALID(c_v), .CMD_READY(c_rdy), .LIMIT_SELECT_CONTACT_N(c_n),
      .TORQUE_DEMAND(t_d), .TORQUE_VALID(t_v));
   cmd_source_model src (.clk(clk), .cmd_mv(c_mv), .cmd_valid(c_v), .cmd_ready(c_rdy), .contact_n(c_n));
   always #5 clk = ~clk;
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic summarize;
      $display("Compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic ck(input bit ok);
      compares++;
      if (!ok) begin
         n_fail++;
         $display("Error at %0t: mismatch", $time);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                     input logic [3:0] s = 4'hF);
      int n = 0;
      aw_a <= a;
      w_d <= d;
      w_s <= s;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
      end while (b_v !== 1'b1 && n < 50);
      ck(b_v === 1'b1 && b_rs === er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      int n = 0;
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (ar_rdy) ar_v <= 1'b0;
      end while (r_v !== 1'b1 && n < 50);
      ck(r_v === 1'b1 && r_d === e && r_rs === er);
   endtask
   task automatic wt;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (t_v !== 1'b1 && n < 100);
   endtask
   task automatic cmd(input logic signed [CMD_W-1:0] mv, input logic [31:0] e);
      src.send(mv);
      wt();
      ck(t_v === 1'b1 && {{3{t_d[SCALED_W-1]}}, t_d} === e);
   endtask
   task automatic t_regs;
      logic [31:0] dv [6] = '{32'h0000_0001, 32'h0000_0064, 32'h0, 32'h0, 32'h0000_0064, 32'h0000_0064};
      for (int i = 0; i < 6; i++) rd(8'(4 * i), dv[i]);
      wr(OFF_MAX_PCT, 32'h0000_0BB8);
      rd(OFF_MAX_PCT, 32'h0000_07D0);
      wr(OFF_MAX_PCT, 32'h0000_0020, RESP_OKAY, 4'h1);
      rd(OFF_MAX_PCT, 32'h0000_0720);
      wr(OFF_BIAS, 32'hFFFF_DCD8);
      rd(OFF_BIAS, 32'hFFFF_E0C0);
      wr(OFF_FILT_TC, 32'h0000_1770);
      rd(OFF_FILT_TC, 32'h0000_1388);
      wr(OFF_LIM_PRI, 32'h0000_0096);
      rd(OFF_LIM_PRI, 32'h0000_0064);
      wr(8'h40, 32'h0000_0001, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(OFF_BIAS, 32'h0);
      wr(OFF_FILT_TC, 32'h0);
   endtask
   task automatic t_scale;
      wr(OFF_MAX_PCT, 32'h0000_0064);
      cmd(16'sd10000, 32'(10000 * 100));
      cmd(-16'sd5000, 32'(-5000 * 100));
      wr(OFF_MAX_PCT, 32'h0000_0032);
      cmd(16'sd10000, 32'(10000 * 50));
      wr(OFF_MAX_PCT, 32'h0);
      cmd(16'sd7000, 32'h0);
      wr(OFF_MAX_PCT, 32'h0000_0064);
      wr(OFF_BIAS, 32'h0000_01F4);
      cmd(16'sd500, 32'h0);
      cmd(16'sd3000, 32'(2500 * 100));
      wr(OFF_BIAS, 32'h0);
   endtask
   task automatic t_limit;
      wr(OFF_MAX_PCT, 32'h0000_00C8);
      cmd(-16'sd10000, 32'(-100 * 10000));
      wr(OFF_LIM_PRI, 32'h0000_0050);
      src.set_contact(1'b0);
      wr(OFF_LIM_SEC, 32'h0000_001E);
      cmd(16'sd10000, 32'(80 * 10000));
      wr(OFF_CTRL, 32'h0000_0003);
      cmd(16'sd10000, 32'(30 * 10000));
      cmd(-16'sd10000, 32'(-30 * 10000));
      rd(OFF_STATUS, 32'h0000_0003);
      src.set_contact(1'b1);
      repeat (4) @(posedge clk);
      cmd(16'sd10000, 32'(80 * 10000));
      src.set_contact(1'b0);
      wr(OFF_LIM_SEC, 32'h0000_005A);
      cmd(16'sd10000, 32'(80 * 10000));
      src.set_contact(1'b1);
      wr(OFF_LIM_PRI, 32'h0000_0064);
      wr(OFF_MAX_PCT, 32'h0000_0064);
   endtask
   task automatic t_filter;
      logic [31:0] d;
      cmd(16'sd0, 32'h0);
      wr(OFF_FILT_TC, 32'h0000_0001);
      src.send(16'sd10000);
      wt();
      d = {{3{t_d[SCALED_W-1]}}, t_d};
      ck(t_v === 1'b1 && d === 32'(100000000 / 1100));
      wr(OFF_CTRL, 32'h0000_0002);
      cmd(16'sd4000, 32'(4000 * 100));
      wr(OFF_CTRL, 32'h0000_0001);
      wr(OFF_FILT_TC, 32'h0);
      cmd(16'sd2000, 32'(2000 * 100));
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_scale();
      t_limit();
      t_filter();
      summarize();
   end
endmodule
